//--- rtl/tsdr_defines.vh
`ifndef TSDR_DEFINES_VH
`define TSDR_DEFINES_VH

// register numbers of the processor-status space
`define TSDR_ADDR_OSC_CTRL 8'h06
`define TSDR_ADDR_TILE_CELL 8'h07
`define TSDR_ADDR_TILE_WIRE 8'h08
`define TSDR_ADDR_PERI_CELL 8'h09
`define TSDR_ADDR_PERI_WIRE 8'h0a
`define TSDR_ADDR_MEM_SIZE 8'h0c
`define TSDR_ADDR_DBG_STATUS 8'h10
`define TSDR_ADDR_DBG_PC 8'h11
`define TSDR_ADDR_DBG_SP 8'h12
`define TSDR_ADDR_THREAD_SEL 8'h13
`define TSDR_ADDR_REG_SEL 8'h14
`define TSDR_ADDR_IRQ_CAUSE 8'h15
`define TSDR_ADDR_IRQ_INFO 8'h16

// oscillator control bits
`define TSDR_OSC_CORE_BIT 1
`define TSDR_OSC_PERI_BIT 0
`define TSDR_OSC_CTRL_RESET 2'h0

// field widths and positions
`define TSDR_OSC_CNT_W 16
`define TSDR_STATUS_W 11
`define TSDR_STATUS_RSVD_BIT 5
`define TSDR_STATUS_ISSUE_BIT 8
`define TSDR_THREAD_W 8
`define TSDR_REGSEL_W 5
`define TSDR_CAUSE_W 3
`define TSDR_CAUSE_THREAD_LSB 8
`define TSDR_HIT_LSB 16
`define TSDR_HIT_W 2
`define TSDR_MEM_SIZE_LSB 2

// debug interrupt cause codes
`define TSDR_CAUSE_NONE 3'h0
`define TSDR_CAUSE_HOST 3'h1
`define TSDR_CAUSE_DEBUG_CALL_INSTR 3'h2
`define TSDR_CAUSE_IBREAK 3'h3
`define TSDR_CAUSE_DWATCH 3'h4
`define TSDR_CAUSE_RWATCH 3'h5

// enable synchroniser depth in oscillator domain
`define TSDR_SYNC_STAGES 2

`endif

//--- rtl/tsdr_osc_counter.v
`timescale 1ns/1ps
`include "tsdr_defines.vh"

// counter clocked by one ring oscillator; no reset, the count survives resets
module tsdr_osc_counter #(
   parameter CNT_W = `TSDR_OSC_CNT_W
) (
   // oscillator
   input wire oscClk,
   // control from core domain, a level
   input wire runReq,
   // count, quasi-static once stopped
   output wire [CNT_W-1:0] count
);

   reg runMeta;
   reg runSync;
   // power-on value only; no reset ever clears the count
   reg [CNT_W-1:0] countReg = {CNT_W{1'b0}};

   // level crossing into the oscillator domain
   always @(posedge oscClk) begin
      runMeta <= runReq;
      runSync <= runMeta;
   end

   // one step per oscillator cycle while running, wraps, holds when stopped
   always @(posedge oscClk) begin
      if (runSync) begin
         countReg <= countReg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign count = countReg;

endmodule // tsdr_osc_counter

//--- rtl/tsdr_status_regs.v
`timescale 1ns/1ps
`include "tsdr_defines.vh"

// How it works
// - four free-running ring oscillators, each feeding its own counter
// - control bit 1 runs core oscillators, bit 0 peripheral ones; both reset zero
// - oscillators run asynchronously to the tile clock, usable as random source
// - each count register shows 16 bits in 15:0, upper bits read zero
// - oscillator counts are never cleared by reset
// - counts mapped tile cell 0x07, tile wire 0x08, periph cell 0x09, wire 0x0a
// - memory size register read-only, size in bits 31:2, low bits zero
// - debugger entry captures the saved status word
// - debugger entry captures saved program counter and stack pointer, both read-write
// - status bits 0..4 events, interrupts, event sequence, handler, kernel; 5 reserved
// - status bits 6 paused, 7 fast, 8 issue mode, 9 kernel issue, 10 space id
// - thread-select operand holds logical core number in bits 7:0
// - register-select operand holds register index in bits 4:0
// - cause field 2:0 codes 1..5, resets to zero
// - bits 17:16 lowest hit breakpoint number, zero for host and debug call
// - bits 15:8 causing thread number, zero for host requests
// - info register gets watch address or resource identifier on a hit
module tsdr_status_regs #(
   parameter MEM_BYTES = 32'h0010_0000,
   parameter CNT_W = `TSDR_OSC_CNT_W
) (
   // clock, reset, enable
   input wire core_clk,
   input wire arst_n,
   input wire coreEn,
   // status access instructions
   input wire [7:0] psAddr,
   input wire psWrite,
   input wire psRead,
   input wire [31:0] psWrData,
   output reg [31:0] psRdData,
   output reg psRdValid,
   // ring oscillators
   input wire tileCellOscClk,
   input wire tileWireOscClk,
   input wire periCellOscClk,
   input wire periWireOscClk,
   // debugger entry
   input wire dbgEnter,
   input wire [`TSDR_STATUS_W-1:0] entryStatus,
   input wire [31:0] entryPc,
   input wire [31:0] entrySp,
   input wire [`TSDR_CAUSE_W-1:0] entryCause,
   input wire [`TSDR_THREAD_W-1:0] entryThread,
   input wire [3:0] entryHits,
   input wire [31:0] entryAddr,
   input wire [31:0] entryResource,
   // register contents toward the core
   output wire coreOscRun,
   output wire periOscRun,
   output wire [`TSDR_STATUS_W-1:0] dbgStatus,
   output wire [31:0] dbgPc,
   output wire [31:0] dbgSp,
   output wire [`TSDR_THREAD_W-1:0] readThreadSel,
   output wire [`TSDR_REGSEL_W-1:0] readRegSel
);

   reg [1:0] oscCtrl;
   reg [`TSDR_STATUS_W-1:0] statusReg;
   reg [31:0] pcReg;
   reg [31:0] spReg;
   reg [`TSDR_THREAD_W-1:0] threadSel;
   reg [`TSDR_REGSEL_W-1:0] regSel;
   reg [`TSDR_CAUSE_W-1:0] causeReg;
   reg [`TSDR_THREAD_W-1:0] causeThread;
   reg [`TSDR_HIT_W-1:0] hitReg;
   reg [31:0] infoReg;
   reg [31:0] next_rdData;
   wire [CNT_W-1:0] tileCellCnt;
   wire [CNT_W-1:0] tileWireCnt;
   wire [CNT_W-1:0] periCellCnt;
   wire [CNT_W-1:0] periWireCnt;
   wire wrEn;
   wire isHost;
   wire isBreak;
   wire [`TSDR_STATUS_W-1:0] statusWrMask;
   wire selStatus;
   wire selPc;
   wire selSp;
   wire selCause;
   wire selInfo;

   // lowest-numbered hit wins
   function [`TSDR_HIT_W-1:0] lowestHit;
      input [3:0] hits;
      begin
         if (hits[0]) begin
            lowestHit = 2'h0;
         end else if (hits[1]) begin
            lowestHit = 2'h1;
         end else if (hits[2]) begin
            lowestHit = 2'h2;
         end else if (hits[3]) begin
            lowestHit = 2'h3;
         end else begin
            lowestHit = 2'h0;
         end
      end
   endfunction

   // zero-extend a count to a word
   function [31:0] countWord;
      input [CNT_W-1:0] cnt;
      begin
         countWord = {{(32-CNT_W){1'b0}}, cnt};
      end
   endfunction

   // debug interrupt type word from its three fields
   function [31:0] causeWord;
      input [`TSDR_CAUSE_W-1:0] cause;
      input [`TSDR_THREAD_W-1:0] thread;
      input [`TSDR_HIT_W-1:0] hit;
      begin
         causeWord = 32'h0000_0000;
         causeWord[`TSDR_CAUSE_W-1:0] = cause;
         causeWord[`TSDR_CAUSE_THREAD_LSB +: `TSDR_THREAD_W] = thread;
         causeWord[`TSDR_HIT_LSB +: `TSDR_HIT_W] = hit;
      end
   endfunction

   // debugger write of the status word keeps the read-only bits
   function [`TSDR_STATUS_W-1:0] mergeStatus;
      input [`TSDR_STATUS_W-1:0] oldVal;
      input [`TSDR_STATUS_W-1:0] newVal;
      input [`TSDR_STATUS_W-1:0] wrMask;
      begin
         mergeStatus = (newVal & wrMask) | (oldVal & ~wrMask);
      end
   endfunction

   assign coreOscRun = oscCtrl[`TSDR_OSC_CORE_BIT];
   assign periOscRun = oscCtrl[`TSDR_OSC_PERI_BIT];

   // each counter on its own free-running oscillator clock
   tsdr_osc_counter #(.CNT_W(CNT_W)) uTileCell (
      .oscClk(tileCellOscClk),
      .runReq(coreOscRun),
      .count(tileCellCnt)
   );
   tsdr_osc_counter #(.CNT_W(CNT_W)) uTileWire (
      .oscClk(tileWireOscClk),
      .runReq(coreOscRun),
      .count(tileWireCnt)
   );
   tsdr_osc_counter #(.CNT_W(CNT_W)) uPeriCell (
      .oscClk(periCellOscClk),
      .runReq(periOscRun),
      .count(periCellCnt)
   );
   tsdr_osc_counter #(.CNT_W(CNT_W)) uPeriWire (
      .oscClk(periWireOscClk),
      .runReq(periOscRun),
      .count(periWireCnt)
   );

   assign wrEn = coreEn && psWrite;
   // write selects of the debug registers
   assign selStatus = (psAddr == `TSDR_ADDR_DBG_STATUS);
   assign selPc = (psAddr == `TSDR_ADDR_DBG_PC);
   assign selSp = (psAddr == `TSDR_ADDR_DBG_SP);
   assign selCause = (psAddr == `TSDR_ADDR_IRQ_CAUSE);
   assign selInfo = (psAddr == `TSDR_ADDR_IRQ_INFO);
   assign isHost = (entryCause == `TSDR_CAUSE_HOST);
   assign isBreak = (entryCause == `TSDR_CAUSE_IBREAK) || (entryCause == `TSDR_CAUSE_DWATCH) ||
                    (entryCause == `TSDR_CAUSE_RWATCH);
   // issue mode and reserved bit are not writable by the debugger
   assign statusWrMask = ~((`TSDR_STATUS_W'h1 << `TSDR_STATUS_ISSUE_BIT) |
                           (`TSDR_STATUS_W'h1 << `TSDR_STATUS_RSVD_BIT));

   // oscillator control and operand registers
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         oscCtrl <= `TSDR_OSC_CTRL_RESET;
         threadSel <= {`TSDR_THREAD_W{1'b0}};
         regSel <= {`TSDR_REGSEL_W{1'b0}};
      end else if (wrEn) begin
         case (psAddr)
            `TSDR_ADDR_OSC_CTRL: oscCtrl <= psWrData[1:0];
            `TSDR_ADDR_THREAD_SEL: threadSel <= psWrData[`TSDR_THREAD_W-1:0];
            `TSDR_ADDR_REG_SEL: regSel <= psWrData[`TSDR_REGSEL_W-1:0];
            default: ;
         endcase
      end
   end

   // saved status word; entry wins over a debugger write in the same cycle
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         statusReg <= {`TSDR_STATUS_W{1'b0}};
      end else if (coreEn) begin
         if (dbgEnter) begin
            statusReg <= entryStatus & ~(`TSDR_STATUS_W'h1 << `TSDR_STATUS_RSVD_BIT);
         end else if (psWrite && selStatus) begin
            statusReg <= mergeStatus(statusReg, psWrData[`TSDR_STATUS_W-1:0], statusWrMask);
         end
      end
   end

   // saved program counter and stack pointer
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pcReg <= 32'h0000_0000;
         spReg <= 32'h0000_0000;
      end else if (coreEn) begin
         if (dbgEnter) begin
            pcReg <= entryPc;
            spReg <= entrySp;
         end else if (psWrite) begin
            if (selPc) begin
               pcReg <= psWrData;
            end
            if (selSp) begin
               spReg <= psWrData;
            end
         end
      end
   end

   // interrupt cause, causing thread and hit number
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         causeReg <= `TSDR_CAUSE_NONE;
         causeThread <= {`TSDR_THREAD_W{1'b0}};
         hitReg <= {`TSDR_HIT_W{1'b0}};
      end else if (coreEn) begin
         if (dbgEnter) begin
            causeReg <= entryCause;
            causeThread <= isHost ? {`TSDR_THREAD_W{1'b0}} : entryThread;
            hitReg <= isBreak ? lowestHit(entryHits) : {`TSDR_HIT_W{1'b0}};
         end else if (psWrite && selCause) begin
            causeReg <= psWrData[`TSDR_CAUSE_W-1:0];
            causeThread <= psWrData[`TSDR_CAUSE_THREAD_LSB +: `TSDR_THREAD_W];
            hitReg <= psWrData[`TSDR_HIT_LSB +: `TSDR_HIT_W];
         end
      end
   end

   // interrupt data; of the entries only watchpoint ones load it, debugger writes load it too
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         infoReg <= 32'h0000_0000;
      end else if (coreEn) begin
         if (dbgEnter) begin
            if (entryCause == `TSDR_CAUSE_DWATCH) begin
               infoReg <= entryAddr;
            end else if (entryCause == `TSDR_CAUSE_RWATCH) begin
               infoReg <= entryResource;
            end
         end else if (psWrite && selInfo) begin
            infoReg <= psWrData;
         end
      end
   end

   // read decode
   always @* begin
      next_rdData = 32'h0000_0000;
      case (psAddr)
         `TSDR_ADDR_OSC_CTRL: next_rdData = {30'h0, oscCtrl};
         `TSDR_ADDR_TILE_CELL: next_rdData = countWord(tileCellCnt);
         `TSDR_ADDR_TILE_WIRE: next_rdData = countWord(tileWireCnt);
         `TSDR_ADDR_PERI_CELL: next_rdData = countWord(periCellCnt);
         `TSDR_ADDR_PERI_WIRE: next_rdData = countWord(periWireCnt);
         `TSDR_ADDR_MEM_SIZE: begin
            next_rdData = {MEM_BYTES[31:`TSDR_MEM_SIZE_LSB], 2'h0};
         end
         `TSDR_ADDR_DBG_STATUS: next_rdData = {21'h0, statusReg};
         `TSDR_ADDR_DBG_PC: next_rdData = pcReg;
         `TSDR_ADDR_DBG_SP: next_rdData = spReg;
         `TSDR_ADDR_THREAD_SEL: next_rdData = {24'h0, threadSel};
         `TSDR_ADDR_REG_SEL: next_rdData = {27'h0, regSel};
         `TSDR_ADDR_IRQ_CAUSE: begin
            next_rdData = causeWord(causeReg, causeThread, hitReg);
         end
         `TSDR_ADDR_IRQ_INFO: next_rdData = infoReg;
         default: next_rdData = 32'h0000_0000;
      endcase
   end

   // counts are sampled directly; software waits for them to settle
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         psRdData <= 32'h0000_0000;
         psRdValid <= 1'b0;
      end else if (coreEn) begin
         psRdValid <= psRead;
         if (psRead) begin
            psRdData <= next_rdData;
         end
      end
   end

   assign dbgStatus = statusReg;
   assign dbgPc = pcReg;
   assign dbgSp = spReg;
   assign readThreadSel = threadSel;
   assign readRegSel = regSel;

endmodule // tsdr_status_regs

//--- verification/tsdr_status_regs_chk.sv
`timescale 1ns/1ps
`include "tsdr_defines.vh"
module tsdr_status_regs_chk #(
   parameter MEM_BYTES = 32'h0
) (
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // status access
   input wire coreEn,
   input wire [7:0] psAddr,
   input wire psWrite,
   input wire psRead,
   input wire [31:0] psWrData,
   input wire [31:0] psRdData,
   input wire psRdValid,
   // debugger entry
   input wire dbgEnter,
   input wire [`TSDR_STATUS_W-1:0] entryStatus,
   input wire [31:0] entryPc,
   input wire [`TSDR_CAUSE_W-1:0] entryCause,
   // register contents
   input wire coreOscRun,
   input wire periOscRun,
   input wire [`TSDR_STATUS_W-1:0] dbgStatus,
   input wire [31:0] dbgPc,
   input wire [`TSDR_THREAD_W-1:0] readThreadSel
);
   wire wrOk = coreEn && psWrite && !dbgEnter;
   wire rdOk = coreEn && psRead;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_host_entry;
      coreEn && dbgEnter && entryCause == 3'h1;
   endsequence
   sequence s_cause_read;
      rdOk && !psWrite && !dbgEnter && psAddr == 8'h15;
   endsequence
   chk_ctrl_core_bit: assert property (coreEn && psWrite && psAddr == 8'h06 |=> coreOscRun == $past(psWrData[1]))
      else $error("core oscillator run bit wrong");
   chk_ctrl_peri_bit: assert property (coreEn && psWrite && psAddr == 8'h06 |=> periOscRun == $past(psWrData[0]))
      else $error("peripheral oscillator run bit wrong");
   chk_osc_high_zero: assert property (rdOk && psAddr >= 8'h07 && psAddr <= 8'h0a |=> psRdData[31:16] == 16'h0)
      else $error("count upper bits not zero");
   chk_mem_size_read: assert property (rdOk && psAddr == 8'h0c |=> psRdData == (MEM_BYTES & 32'hffff_fffc))
      else $error("memory size read wrong");
   chk_status_capture: assert property (coreEn && dbgEnter |=> dbgStatus == ($past(entryStatus) & 11'h7df))
      else $error("status not captured");
   chk_pc_capture: assert property (coreEn && dbgEnter |=> dbgPc == $past(entryPc))
      else $error("pc not captured");
   chk_thread_sel_write: assert property (wrOk && psAddr == 8'h13 |=> readThreadSel == $past(psWrData[7:0]))
      else $error("thread select not written");
   chk_status_fixed_bits: assert property (wrOk && psAddr == 8'h10 |=> !dbgStatus[5] && $stable(dbgStatus[8]))
      else $error("fixed status bits changed");
   chk_host_cause_read: assert property (s_host_entry ##1 (!psWrite && !dbgEnter) ##1 s_cause_read |=> psRdValid && psRdData == 32'h1)
      else $error("host cause read wrong");
endmodule // tsdr_status_regs_chk
bind tsdr_status_regs tsdr_status_regs_chk #(.MEM_BYTES(MEM_BYTES)) i_chk (.core_clk, .arst_n, .coreEn, .psAddr,
   .psWrite, .psRead, .psWrData, .psRdData, .psRdValid, .dbgEnter, .entryStatus, .entryPc, .entryCause,
   .coreOscRun, .periOscRun, .dbgStatus, .dbgPc, .readThreadSel);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam MEMB = 32'h0004_0003;
   reg core_clk, arst_n, coreEn, psWrite, psRead, dbgEnter;
   reg [7:0] psAddr, entryThread;
   reg [31:0] psWrData, entryPc, entrySp, entryAddr, entryResource, rv, info;
   reg [31:0] a [0:3];
   reg [31:0] b [0:3];
   reg [10:0] entryStatus;
   reg [2:0] entryCause;
   reg [3:0] entryHits, osc;
   wire [31:0] psRdData, dbgPc, dbgSp;
   wire [10:0] dbgStatus;
   wire [7:0] readThreadSel;
   wire [4:0] readRegSel;
   wire psRdValid, coreOscRun, periOscRun;
   integer err_count, checks_done, cyc, i, c;
   tsdr_status_regs #(.MEM_BYTES(MEMB)) i_dut (.core_clk, .arst_n, .coreEn, .psAddr, .psWrite, .psRead,
      .psWrData, .psRdData, .psRdValid, .tileCellOscClk(osc[0]), .tileWireOscClk(osc[1]),
      .periCellOscClk(osc[2]), .periWireOscClk(osc[3]), .dbgEnter, .entryStatus, .entryPc, .entrySp,
      .entryCause, .entryThread, .entryHits, .entryAddr, .entryResource, .coreOscRun, .periOscRun,
      .dbgStatus, .dbgPc, .dbgSp, .readThreadSel, .readRegSel);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // free-running, unrelated to the core clock
   always #3.1 osc[0] = ~osc[0];
   always #3.7 osc[1] = ~osc[1];
   always #4.3 osc[2] = ~osc[2];
   always #5.9 osc[3] = ~osc[3];
   function [1:0] low(input [3:0] h);
      low = h[0] ? 2'd0 : h[1] ? 2'd1 : h[2] ? 2'd2 : 2'd3;
   endfunction
   task conclude;
      begin
         if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] ad, input [31:0] d);
      begin
         @(negedge core_clk);
         psAddr = ad;
         psWrData = d;
         psWrite = 1'b1;
         @(negedge core_clk);
         psWrite = 1'b0;
      end
   endtask
   task rdraw(input [7:0] ad);
      begin
         @(negedge core_clk);
         psAddr = ad;
         psRead = 1'b1;
         @(negedge core_clk);
         psRead = 1'b0;
         rv = psRdData;
         cmp({31'h0, psRdValid}, 32'h1);
      end
   endtask
   task rd(input [7:0] ad, input [31:0] exp);
      begin
         rdraw(ad);
         cmp(rv, exp);
      end
   endtask
   task do_reset;
      begin
         arst_n = 1'b0;
         repeat (20) @(negedge core_clk);
         arst_n = 1'b1;
      end
   endtask
   // counts are read only after the oscillators stood still
   task snap;
      begin
         repeat (12) @(negedge core_clk);
         for (i = 0; i < 4; i = i + 1) begin
            rdraw(8'h07 + i[7:0]);
            a[i] = rv;
            cmp(rv >> 16, 32'h0);
         end
      end
   endtask
   task run(input [1:0] m);
      begin
         for (i = 0; i < 4; i = i + 1) b[i] = a[i];
         wr(8'h06, {30'h0, m});
         repeat (40) @(negedge core_clk);
         wr(8'h06, 32'h0);
         snap;
         for (i = 0; i < 4; i = i + 1) begin
            if (!m[i < 2]) cmp(a[i], b[i]);
            else if (^{a[i], b[i]} !== 1'bx) cmp({31'h0, a[i] != b[i]}, 32'h1);
         end
      end
   endtask
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         conclude;
      end
   end
   initial begin
      {coreEn, psWrite, psRead, dbgEnter, psAddr, psWrData} = {3'b100, 1'b0, 40'h0};
      {entryThread, entryPc, entrySp, entryAddr, entryResource, entryStatus, entryCause, entryHits} = 0;
      {osc, err_count, checks_done, cyc} = 0;
      do_reset;
      rd(8'h06, 32'h0);
      rd(8'h15, 32'h0);
      rd(8'h0b, 32'h0);
      wr(8'h06, 32'hffff_ffff);
      rd(8'h06, 32'h3);
      cmp({30'h0, coreOscRun, periOscRun}, 32'h3);
      wr(8'h0c, 32'h0);
      rd(8'h0c, MEMB & 32'hffff_fffc);
      wr(8'h06, 32'h0);
      snap;
      run(2'b10);
      run(2'b01);
      run(2'b11);
      for (i = 0; i < 4; i = i + 1) b[i] = a[i];
      do_reset;
      snap;
      for (i = 0; i < 4; i = i + 1) cmp(a[i], b[i]);
      wr(8'h16, 32'hcafe_0001);
      info = 32'hcafe_0001;
      for (c = 1; c < 6; c = c + 1) begin
         @(negedge core_clk);
         entryCause = c[2:0];
         entryHits = 4'hf << (c - 2);
         entryThread = 8'h20 + c[7:0];
         entryStatus = 11'h7f0 | c[10:0];
         {entryPc, entrySp, entryAddr, entryResource} = {4{32'h8000_0000 | c}} ^ {32'h0, {3{32'h1000}}};
         dbgEnter = 1'b1;
         @(negedge core_clk);
         dbgEnter = 1'b0;
         if (c == 4) info = entryAddr;
         if (c == 5) info = entryResource;
         rd(8'h15, {14'h0, (c > 2 ? low(entryHits) : 2'h0), (c == 1 ? 8'h0 : entryThread), 5'h0, c[2:0]});
         rd(8'h10, {21'h0, entryStatus & 11'h7df});
         rd(8'h11, entryPc);
         rd(8'h12, entrySp);
         cmp(dbgSp, entrySp);
         rd(8'h16, info);
      end
      wr(8'h10, 32'h0);
      rd(8'h10, 32'h100);
      wr(8'h11, 32'h1234_5678);
      rd(8'h11, 32'h1234_5678);
      // clock enable low: write, read and capture all frozen
      @(negedge core_clk);
      {coreEn, psAddr, psWrData, psWrite, psRead, dbgEnter} = {1'b0, 8'h11, 32'h0bad_0bad, 3'b111};
      @(negedge core_clk);
      {coreEn, psWrite, psRead, dbgEnter} = 4'b1000;
      cmp({31'h0, psRdValid}, 32'h0);
      rd(8'h11, 32'h1234_5678);
      wr(8'h13, 32'hffff_ffff);
      rd(8'h13, 32'hff);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h14, 32'h1f);
      cmp({19'h0, readRegSel, readThreadSel}, 32'h1fff);
      conclude;
   end
endmodule // testbench
